// ---- src/scrc_consts.svh ----
`ifndef SCRC_CONSTS_SVH
`define SCRC_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SCRC_OFF_CTRL1   12'h000
`define SCRC_OFF_CTRL2   12'h004
`define SCRC_OFF_PADS    12'h008
`define SCRC_OFF_IEN     12'h00c
`define SCRC_OFF_ISTAT   12'h010
`define SCRC_OFF_RXTH    12'h01c
`define SCRC_OFF_REP     12'h020
`define SCRC_OFF_GUARD   12'h02c
`define SCRC_OFF_GAPLIM  12'h03c
`define SCRC_OFF_DEBOUNCE 12'h058
`define SCRC_OFF_FIFO    12'h200

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SCRC_C1_MASK     16'h8fc7
`define SCRC_C1_GIE      15
`define SCRC_C1_PROT     11
`define SCRC_C1_KEEPTS   10
`define SCRC_C1_RXA      9
`define SCRC_C1_TXA      8
`define SCRC_C1_HLEV     7
`define SCRC_C1_HALT     6
`define SCRC_C1_KEEPPE   2
`define SCRC_C1_MSB      1
`define SCRC_C1_INV      0
`define SCRC_C2_DOWN     4
`define SCRC_C2_UP       3
`define SCRC_C2_WARM     2
`define SCRC_PD_FCB      8
`define SCRC_PD_PP       7
`define SCRC_PD_VPPEN    6
`define SCRC_PD_AUTO     5
`define SCRC_PD_VCC      4
`define SCRC_PD_RST      3
`define SCRC_PD_CLK      2
`define SCRC_PD_IO       1
`define SCRC_PD_RAW      0
`define SCRC_EV_RXCHAR   0
`define SCRC_EV_RX_PARITY_IRQ   1
`define SCRC_EV_TX_PARITY_IRQ   2
`define SCRC_EV_GAP      3
`define SCRC_EV_ACK      4
`define SCRC_RESET16     16'h0000
`define SCRC_FIFO_DEPTH  3'd4

// ----------------------------------------
// timing
// ----------------------------------------
`define SCRC_CHAR_ETU    20'd12
`define SCRC_T1_MIN_ETU  20'd11
`define SCRC_TURN_T0_ETU 20'd16
`define SCRC_TURN_T1_ETU 20'd22
`define SCRC_GUARD_MAX   8'hff
`define SCRC_RX_ERR_IDX  4'd10
`define SCRC_RX_END_IDX  4'd11
`define SCRC_TX_ERR_IDX  4'd13
`define SCRC_CLK_NS      100
`define SCRC_STEP_CYC    17'd16
`define SCRC_HALT_CYC    8'd16
`define SCRC_RESUME_CYC  8'd16
`define SCRC_CLASS_GAP_MS 10
`define SCRC_CLASS_GAP_CYC ((`SCRC_CLASS_GAP_MS * 1000000) / `SCRC_CLK_NS)
`define SCRC_RST_LOW_CYC 80000
`define SCRC_ATR_WAIT_CYC 80000

`endif

// ---- src/scrc_pkg.sv ----
package scrc_pkg;

	typedef enum logic [2:0] {
		SEQ_OFF   = 3'h0,
		SEQ_PWR   = 3'h1,
		SEQ_CLK   = 3'h3,
		SEQ_RSTLO = 3'h2,
		SEQ_ATRW  = 3'h6,
		SEQ_ON    = 3'h7,
		SEQ_DOWN  = 3'h5,
		SEQ_GAP   = 3'h4
	} scrc_seq_e;

	typedef enum logic [1:0] {
		LNK_IDLE = 2'h0,
		LNK_TX   = 2'h1,
		LNK_RX   = 2'h3,
		LNK_ERR  = 2'h2
	} scrc_lnk_e;

	typedef struct packed {
		logic        offer;
		logic        prot;
		logic        msb;
		logic        inv;
		logic        rxA;
		logic        txA;
		logic        raw;
		logic        dirIo;
		logic        gapOn;
		logic        powered;
		logic [7:0]  guard;
		logic [7:0]  rep;
		logic [15:0] gapLim;
	} scrc_cfg_s;

	typedef struct packed {
		logic [15:0]      ctrl1;
		logic [2:0]       cls;
		logic             upReq;
		logic             downReq;
		logic             warmReq;
		logic [8:0]       pads;
		logic [15:0]      ien;
		logic [15:0]      ist;
		logic [15:0]      rxTh;
		logic [7:0]       rep;
		logic [7:0]       guard;
		logic [15:0]      gapLim;
		logic [15:0]      dbTime;
		logic [15:0]      rdata;
		logic [3:0][7:0]  rxMem;
		logic [1:0]       rxWr;
		logic [1:0]       rxRd;
		logic [2:0]       rxCnt;
		logic [3:0][7:0]  txMem;
		logic [1:0]       txWr;
		logic [1:0]       txRd;
		logic [2:0]       txCnt;
		logic [7:0]       txHold;
		logic             txOffer;
		logic             txOk;
		scrc_seq_e        seq;
		logic [16:0]      timer;
		logic [1:0]       step;
		logic [1:0]       tryCls;
		logic [2:0]       tryMask;
		logic             nextCls;
		logic             vccOn;
		logic             clkOn;
		logic             rstHi;
		logic             atrFirst;
		logic             gapOn;
		logic             detS1;
		logic             detS2;
		logic [15:0]      dbCnt;
		logic             present;
		logic [4:0]       evS1;
		logic [4:0]       evS2;
		logic [4:0]       evS3;
		logic             busyS1;
		logic             busyS2;
		logic             ccDiv;
		logic             stopped;
		logic             resuming;
		logic [7:0]       haltCnt;
		logic             cardClk;
		logic             cardRstN;
		logic [2:0]       supply;
		logic             vppEn;
		logic             vppPp;
		logic             fcb;
		logic             irq;
	} scrc_core_s;

	typedef struct packed {
		scrc_cfg_s   cfgS1;
		scrc_cfg_s   cfgS2;
		logic        ioS1;
		logic        ioS2;
		scrc_lnk_e   st;
		logic [3:0]  idx;
		logic [8:0]  rxLine;
		logic [3:0]  rxTry;
		logic [3:0]  txTry;
		logic [4:0]  evTgl;
		logic [7:0]  rxByte;
		logic        rxBad;
		logic [19:0] sinceLead;
		logic        lastRx;
		logic        drvLow;
		logic        busy;
		logic        ioOeN;
	} scrc_link_s;

endpackage : scrc_pkg

// ---- src/scrc_top.sv ----
`timescale 1ns/1ps
`include "scrc_consts.svh"

module scrc_top import scrc_pkg::*; #(
	parameter int CLASS_GAP_CYC = `SCRC_CLASS_GAP_CYC,
	parameter int RST_LOW_CYC   = `SCRC_RST_LOW_CYC,
	parameter int ATR_WAIT_CYC  = `SCRC_ATR_WAIT_CYC
)(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        linkClk,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cardDetectInput,
	input  wire logic        cardIoIn,
	output logic             cardIoOut,
	output logic             cardIoOeN,
	output logic             cardClk,
	output logic             cardResetN,
	output logic             supplyA,
	output logic             supplyB,
	output logic             supplyC,
	output logic             progSupply,
	output logic             progPause,
	output logic             functionCode,
	output logic             irq
);

	scrc_core_s cR;
	scrc_core_s c;
	scrc_link_s lR;
	scrc_link_s l;
	scrc_cfg_s  cfgIn;
	logic [15:0] evSet;
	logic [4:0]  evEdge;
	logic        wr;
	logic        rxPush;
	logic        rxPop;
	logic        txPush;
	logic        txPop;
	logic        txIdle;
	logic [19:0] need;
	logic [8:0]  dec;
	logic [8:0]  rxDec;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [2:0] clsOneHot(input logic [1:0] k);
		clsOneHot = 3'h1 << k;
	endfunction : clsOneHot

	function automatic logic [1:0] lowestCls(input logic [2:0] m);
		lowestCls = m[0] ? 2'h0 : (m[1] ? 2'h1 : 2'h2);
	endfunction : lowestCls

	function automatic logic mapped(input logic [11:0] a);
		case (a)
			`SCRC_OFF_CTRL1, `SCRC_OFF_CTRL2, `SCRC_OFF_PADS,
			`SCRC_OFF_IEN, `SCRC_OFF_ISTAT, `SCRC_OFF_RXTH,
			`SCRC_OFF_REP, `SCRC_OFF_GUARD, `SCRC_OFF_GAPLIM,
			`SCRC_OFF_DEBOUNCE, `SCRC_OFF_FIFO: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	function automatic logic txLine(input logic [7:0] b, input logic [3:0] i,
			input logic msb, input logic inv);
		logic [2:0] k;
		logic       v;
		k = 3'(i - 4'h1);
		if (i == 4'h9) begin
			v = ^b;
		end else begin
			v = msb ? b[3'h7 - k] : b[k];
		end
		txLine = inv ? ~v : v;
	endfunction : txLine

	function automatic logic [8:0] rxDecode(input logic [8:0] ln,
			input logic msb, input logic inv);
		logic [7:0] b;
		logic [8:0] v;
		v = inv ? ~ln : ln;
		for (int i = 0; i < 8; i++) begin
			b[msb ? 7 - i : i] = v[i];
		end
		rxDecode = {^v, b};
	endfunction : rxDecode

	// ----------------------------------------
	// register side
	// ----------------------------------------
	assign cfgIn = '{offer: cR.txOffer, prot: cR.ctrl1[`SCRC_C1_PROT],
		msb: cR.ctrl1[`SCRC_C1_MSB], inv: cR.ctrl1[`SCRC_C1_INV],
		rxA: cR.ctrl1[`SCRC_C1_RXA], txA: cR.txOk,
		raw: cR.pads[`SCRC_PD_RAW], dirIo: cR.pads[`SCRC_PD_IO],
		gapOn: cR.gapOn, powered: cR.clkOn, guard: cR.guard,
		rep: cR.rep, gapLim: cR.gapLim};

	always_comb begin
		c = cR;
		evSet = 16'h0000;
		wr = psel & penable & pwrite;
		c.detS1 = cardDetectInput;
		c.detS2 = cR.detS1;
		c.evS1 = lR.evTgl;
		c.evS2 = cR.evS1;
		c.evS3 = cR.evS2;
		c.busyS1 = lR.busy;
		c.busyS2 = cR.busyS1;
		evEdge = cR.evS2 ^ cR.evS3;
		txIdle = cR.txOffer == cR.evS2[`SCRC_EV_ACK];

		// card detect debounce
		if (cR.detS2) begin
			if (cR.dbCnt != 16'hffff)
				c.dbCnt = cR.dbCnt + 16'h1;
			if (cR.dbCnt >= cR.dbTime && !cR.present) begin
				c.present = 1'b1;
				evSet[13] = 1'b1;
			end
		end else begin
			c.dbCnt = 16'h0000;
			c.present = 1'b0;
			evSet[12] = cR.present;
		end

		// receive storage
		dec = {lR.rxBad, lR.rxByte};
		rxPop = psel & penable & ~pwrite & (paddr == `SCRC_OFF_FIFO)
			& (cR.rxCnt != 3'h0);
		rxPush = evEdge[`SCRC_EV_RXCHAR] & (cR.rxCnt != `SCRC_FIFO_DEPTH)
			& (~dec[8] | cR.ctrl1[`SCRC_C1_KEEPPE])
			& (~cR.atrFirst | cR.ctrl1[`SCRC_C1_KEEPTS]);
		if (rxPush) begin
			c.rxMem[cR.rxWr] = dec[7:0];
			c.rxWr = cR.rxWr + 2'h1;
		end
		if (rxPop)
			c.rxRd = cR.rxRd + 2'h1;
		c.rxCnt = cR.rxCnt + {2'h0, rxPush} - {2'h0, rxPop};

		// transmit storage and offer to the link
		txPush = wr & (paddr == `SCRC_OFF_FIFO)
			& (cR.txCnt != `SCRC_FIFO_DEPTH);
		txPop = txIdle & (cR.txCnt != 3'h0);
		if (txPush) begin
			c.txMem[cR.txWr] = pwdata[7:0];
			c.txWr = cR.txWr + 2'h1;
		end
		if (txPop) begin
			c.txHold = cR.txMem[cR.txRd];
			c.txRd = cR.txRd + 2'h1;
			c.txOffer = ~cR.txOffer;
			evSet[1] = cR.txCnt == 3'h1;
		end
		c.txCnt = cR.txCnt + {2'h0, txPush} - {2'h0, txPop};

		// link events
		evSet[5] = evEdge[`SCRC_EV_RXCHAR];
		evSet[7] = evEdge[`SCRC_EV_RX_PARITY_IRQ];
		evSet[6] = evEdge[`SCRC_EV_TX_PARITY_IRQ];
		evSet[8] = evEdge[`SCRC_EV_GAP];
		evSet[4] = evEdge[`SCRC_EV_ACK];
		evSet[0] = evEdge[`SCRC_EV_ACK] & (cR.txCnt == 3'h0);
		evSet[2] = cR.rxCnt == `SCRC_FIFO_DEPTH;
		evSet[9] = {13'h0, cR.rxCnt} >= cR.rxTh;

		// clock halt and resume
		if (cR.ctrl1[`SCRC_C1_HALT]) begin
			c.resuming = 1'b0;
			if (!cR.stopped && !cR.busyS2 && txIdle) begin
				c.haltCnt = cR.haltCnt + 8'h1;
				if (cR.haltCnt == `SCRC_HALT_CYC - 8'h1) begin
					c.stopped = 1'b1;
					c.haltCnt = 8'h00;
					evSet[3] = 1'b1;
				end
			end else if (!cR.stopped) begin
				c.haltCnt = 8'h00;
			end
		end else if (cR.stopped) begin
			c.stopped = 1'b0;
			c.resuming = 1'b1;
			c.haltCnt = 8'h00;
		end else if (cR.resuming) begin
			c.haltCnt = cR.haltCnt + 8'h1;
			if (cR.haltCnt == `SCRC_RESUME_CYC - 8'h1) begin
				c.resuming = 1'b0;
				c.haltCnt = 8'h00;
				evSet[3] = 1'b1;
			end
		end
		c.ccDiv = c.stopped ? cR.ccDiv : ~cR.ccDiv;
		c.txOk = cR.ctrl1[`SCRC_C1_TXA] & ~cR.ctrl1[`SCRC_C1_HALT]
			& ~c.stopped & ~c.resuming;

		// activation, answer wait, deactivation
		c.warmReq = 1'b0;
		c.timer = cR.timer + 17'h1;
		case (cR.seq)
			SEQ_OFF: begin
				c.timer = 17'h0;
				if (cR.downReq) begin
					c.downReq = 1'b0;
					evSet[15] = 1'b1;
				end else if (cR.upReq && cR.present) begin
					c.tryMask = (cR.cls == 3'h0) ? 3'h7 : cR.cls;
					c.tryCls = lowestCls(c.tryMask);
					c.vccOn = 1'b1;
					c.seq = SEQ_PWR;
				end
			end
			SEQ_PWR: begin
				if (cR.timer == `SCRC_STEP_CYC - 17'h1) begin
					c.timer = 17'h0;
					c.clkOn = 1'b1;
					c.seq = SEQ_CLK;
				end
			end
			SEQ_CLK: begin
				if (cR.timer == `SCRC_STEP_CYC - 17'h1) begin
					c.timer = 17'h0;
					c.seq = SEQ_RSTLO;
				end
			end
			SEQ_RSTLO: begin
				if (cR.timer == 17'(RST_LOW_CYC - 1)) begin
					c.timer = 17'h0;
					c.rstHi = 1'b1;
					c.atrFirst = 1'b1;
					c.gapOn = 1'b1;
					if (cR.upReq) begin
						c.upReq = 1'b0;
						evSet[14] = 1'b1;
					end
					c.seq = SEQ_ATRW;
				end
			end
			SEQ_ATRW: begin
				if (evEdge[`SCRC_EV_RXCHAR]) begin
					c.atrFirst = 1'b0;
					c.cls = clsOneHot(cR.tryCls);
					evSet[11] = 1'b1;
					c.seq = SEQ_ON;
				end else if (cR.timer == 17'(ATR_WAIT_CYC - 1)) begin
					c.tryMask = cR.tryMask & ~clsOneHot(cR.tryCls);
					if (c.tryMask != 3'h0) begin
						c.nextCls = 1'b1;
						c.seq = SEQ_DOWN;
					end else begin
						evSet[10] = 1'b1;
						c.seq = SEQ_ON;
					end
					c.timer = 17'h0;
				end
			end
			SEQ_ON: c.timer = 17'h0;
			SEQ_DOWN: begin
				if (cR.timer == `SCRC_STEP_CYC - 17'h1) begin
					c.timer = 17'h0;
					c.step = cR.step + 2'h1;
					if (cR.step == 2'h0)
						c.clkOn = 1'b0;
					if (cR.step == 2'h1)
						c.vccOn = 1'b0;
					if (cR.step == 2'h2) begin
						c.step = 2'h0;
						c.seq = cR.nextCls ? SEQ_GAP : SEQ_OFF;
						if (!cR.nextCls) begin
							c.downReq = 1'b0;
							evSet[15] = 1'b1;
						end
					end
				end
			end
			SEQ_GAP: begin
				if (cR.timer == 17'(CLASS_GAP_CYC - 1)) begin
					c.timer = 17'h0;
					c.nextCls = 1'b0;
					c.tryCls = lowestCls(cR.tryMask);
					c.vccOn = 1'b1;
					c.seq = SEQ_PWR;
				end
			end
			default: c.seq = SEQ_OFF;
		endcase
		if ((cR.seq == SEQ_ATRW || cR.seq == SEQ_ON) && cR.warmReq) begin
			c.rstHi = 1'b0;
			c.gapOn = 1'b0;
			c.timer = 17'h0;
			c.seq = SEQ_RSTLO;
		end
		if ((cR.downReq || evSet[12]) && cR.seq != SEQ_OFF
				&& cR.seq != SEQ_DOWN) begin
			c.rstHi = 1'b0;
			c.gapOn = 1'b0;
			c.atrFirst = 1'b0;
			c.nextCls = 1'b0;
			c.timer = 17'h0;
			c.step = 2'h0;
			c.seq = SEQ_DOWN;
		end

		// bus writes after hardware updates, so a set wins
		if (wr) begin
			case (paddr)
				`SCRC_OFF_CTRL1: c.ctrl1 = pwdata[15:0] & `SCRC_C1_MASK;
				`SCRC_OFF_CTRL2: begin
					c.cls = pwdata[7:5];
					c.downReq = c.downReq | pwdata[`SCRC_C2_DOWN];
					c.upReq = c.upReq | pwdata[`SCRC_C2_UP];
					c.warmReq = pwdata[`SCRC_C2_WARM];
				end
				`SCRC_OFF_PADS: c.pads = pwdata[8:0];
				`SCRC_OFF_IEN: c.ien = pwdata[15:0];
				`SCRC_OFF_ISTAT: c.ist = cR.ist & ~pwdata[15:0];
				`SCRC_OFF_RXTH: c.rxTh = pwdata[15:0];
				`SCRC_OFF_REP: c.rep = pwdata[7:0];
				`SCRC_OFF_GUARD: c.guard = pwdata[7:0];
				`SCRC_OFF_GAPLIM: c.gapLim = pwdata[15:0];
				`SCRC_OFF_DEBOUNCE: c.dbTime = pwdata[15:0];
				default: c.ist = cR.ist;
			endcase
		end
		c.ist = c.ist | evSet;

		// read data captured in the setup phase
		if (psel && !penable) begin
			case (paddr)
				`SCRC_OFF_CTRL1: c.rdata = {cR.ctrl1[15:7],
					cR.stopped | cR.resuming, cR.ctrl1[5:0]};
				`SCRC_OFF_CTRL2: c.rdata = {8'h00, cR.cls, cR.downReq,
					cR.upReq, 3'h0};
				`SCRC_OFF_PADS: c.rdata = {6'h00, cR.present, cR.pads};
				`SCRC_OFF_IEN: c.rdata = cR.ien;
				`SCRC_OFF_ISTAT: c.rdata = cR.ist;
				`SCRC_OFF_RXTH: c.rdata = cR.rxTh;
				`SCRC_OFF_REP: c.rdata = {8'h00, cR.rep};
				`SCRC_OFF_GUARD: c.rdata = {8'h00, cR.guard};
				`SCRC_OFF_GAPLIM: c.rdata = cR.gapLim;
				`SCRC_OFF_DEBOUNCE: c.rdata = cR.dbTime;
				`SCRC_OFF_FIFO: c.rdata = {8'h00, cR.rxMem[cR.rxRd]};
				default: c.rdata = 16'h0000;
			endcase
		end

		// pads
		if (cR.pads[`SCRC_PD_RAW]) begin
			c.cardClk = c.pads[`SCRC_PD_CLK];
			c.cardRstN = c.pads[`SCRC_PD_RST];
			c.supply = c.pads[`SCRC_PD_VCC] ? c.cls : 3'h0;
		end else begin
			c.cardClk = ~c.clkOn ? 1'b0
				: (c.stopped ? c.ctrl1[`SCRC_C1_HLEV] : c.ccDiv);
			c.cardRstN = c.rstHi;
			c.supply = c.vccOn ? clsOneHot(c.tryCls) : 3'h0;
		end
		c.vppEn = c.pads[`SCRC_PD_AUTO] ? c.vccOn
			: c.pads[`SCRC_PD_VPPEN];
		c.vppPp = c.pads[`SCRC_PD_AUTO] ? c.vccOn
			: c.pads[`SCRC_PD_PP];
		c.fcb = c.pads[`SCRC_PD_FCB];
		c.irq = c.ctrl1[`SCRC_C1_GIE] & |(c.ist & c.ien);
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cR <= '0;
			cR.seq <= SEQ_OFF;
		end else begin
			cR <= c;
		end
	end

	// ----------------------------------------
	// link side, one cycle per ETU
	// ----------------------------------------
	always_comb begin
		l = lR;
		l.cfgS1 = cfgIn;
		l.cfgS2 = lR.cfgS1;
		rxDec = 9'h000;
		l.ioS1 = cardIoIn;
		l.ioS2 = lR.ioS1;
		l.idx = lR.idx + 4'h1;
		if (lR.sinceLead != 20'hfffff)
			l.sinceLead = lR.sinceLead + 20'h1;
		if (lR.cfgS2.gapOn && lR.cfgS2.gapLim != 16'h0000
				&& lR.sinceLead == {lR.cfgS2.gapLim, 4'h0})
			l.evTgl[`SCRC_EV_GAP] = ~lR.evTgl[`SCRC_EV_GAP];
		if (lR.lastRx) begin
			need = lR.cfgS2.prot ? `SCRC_TURN_T1_ETU : `SCRC_TURN_T0_ETU;
		end else if (lR.cfgS2.prot && lR.cfgS2.guard == `SCRC_GUARD_MAX) begin
			need = `SCRC_T1_MIN_ETU;
		end else begin
			need = `SCRC_CHAR_ETU + {12'h000, lR.cfgS2.guard};
		end
		case (lR.st)
			LNK_IDLE: begin
				l.drvLow = 1'b0;
				l.idx = 4'h1;
				if (lR.cfgS2.rxA && !lR.ioS2) begin
					l.st = LNK_RX;
					l.sinceLead = 20'h0;
					l.lastRx = 1'b1;
				end else if (lR.cfgS2.txA
						&& lR.cfgS2.offer != lR.evTgl[`SCRC_EV_ACK]
						&& lR.sinceLead >= need - 20'h1) begin
					l.st = LNK_TX;
					l.drvLow = 1'b1;
					l.sinceLead = 20'h0;
					l.lastRx = 1'b0;
				end
			end
			LNK_TX: begin
				l.drvLow = lR.idx < 4'ha
					&& !txLine(cR.txHold, lR.idx, lR.cfgS2.msb, lR.cfgS2.inv);
				if (lR.idx == `SCRC_TX_ERR_IDX) begin
					l.st = LNK_IDLE;
					if (!lR.ioS2 && !lR.cfgS2.prot
							&& lR.txTry < lR.cfgS2.rep[3:0]) begin
						l.txTry = lR.txTry + 4'h1;
					end else begin
						if (!lR.ioS2)
							l.evTgl[`SCRC_EV_TX_PARITY_IRQ] = ~lR.evTgl[`SCRC_EV_TX_PARITY_IRQ];
						l.txTry = 4'h0;
						l.evTgl[`SCRC_EV_ACK] = ~lR.evTgl[`SCRC_EV_ACK];
					end
				end
			end
			LNK_RX: begin
				l.rxLine[lR.idx - 4'h1] = lR.ioS2;
				if (lR.idx == 4'h9) begin
					rxDec = rxDecode(l.rxLine, lR.cfgS2.msb, lR.cfgS2.inv);
					l.st = LNK_IDLE;
					if (rxDec[8] && !lR.cfgS2.prot
							&& lR.rxTry < lR.cfgS2.rep[7:4]) begin
						l.rxTry = lR.rxTry + 4'h1;
						l.st = LNK_ERR;
					end else begin
						l.rxTry = 4'h0;
						l.rxByte = rxDec[7:0];
						l.rxBad = rxDec[8];
						l.evTgl[`SCRC_EV_RXCHAR] = ~lR.evTgl[`SCRC_EV_RXCHAR];
						if (rxDec[8])
							l.evTgl[`SCRC_EV_RX_PARITY_IRQ] = ~lR.evTgl[`SCRC_EV_RX_PARITY_IRQ];
					end
				end
			end
			LNK_ERR: begin
				l.drvLow = lR.idx == `SCRC_RX_ERR_IDX;
				if (lR.idx == `SCRC_RX_END_IDX)
					l.st = LNK_IDLE;
			end
			default: l.st = LNK_IDLE;
		endcase
		if (lR.cfgS2.raw || !lR.cfgS2.powered) begin
			l.st = LNK_IDLE;
			l.drvLow = 1'b0;
			l.rxTry = 4'h0;
			l.txTry = 4'h0;
		end
		l.busy = l.st != LNK_IDLE;
		l.ioOeN = lR.cfgS2.raw ? lR.cfgS2.dirIo : ~l.drvLow;
	end

	always_ff @(posedge linkClk or negedge resetn) begin
		if (!resetn) begin
			lR <= '0;
			lR.ioOeN <= 1'b1;
			lR.st <= LNK_IDLE;
		end else begin
			lR <= l;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata = {16'h0000, cR.rdata};
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);
	assign cardIoOut = 1'b0;
	assign cardIoOeN = lR.ioOeN;
	assign cardClk = cR.cardClk;
	assign cardResetN = cR.cardRstN;
	assign supplyC = cR.supply[0];
	assign supplyB = cR.supply[1];
	assign supplyA = cR.supply[2];
	assign progSupply = cR.vppEn;
	assign progPause = cR.vppPp;
	assign functionCode = cR.fcb;
	assign irq = cR.irq;

endmodule : scrc_top

// ---- verif/scrc_card_model.sv ----
`timescale 1ns/1ps
module scrc_card_model (
	input  logic linkClk,
	input  logic cardResetN,
	input  logic cardIoOeN,
	output logic cardIoIn
);
	localparam logic [7:0] ATR [2] = '{8'h3b, 8'h5a};
	logic       drv_r = 1'b1;
	logic [9:0] frm;
	// pulled-up open-drain line
	assign cardIoIn = drv_r & cardIoOeN;
	initial begin
		forever begin
			@(posedge cardResetN);
			repeat (3) @(posedge linkClk);
			for (int c = 0; c < 2; c++) begin
				frm = {^ATR[c], ATR[c], 1'b0};
				for (int b = 0; b < 10; b++) begin
					drv_r <= frm[b];
					@(posedge linkClk);
				end
				drv_r <= 1'b1;
				repeat (4) @(posedge linkClk);
			end
		end
	end
endmodule : scrc_card_model

// ---- verif/scrc_top_properties.sv ----
`timescale 1ns/1ps
module scrc_props (
	input logic        core_clk,
	input logic        resetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [11:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        cardDetectInput,
	input logic        cardIoOeN,
	input logic        cardClk,
	input logic        cardResetN,
	input logic        supplyA,
	input logic        supplyB,
	input logic        supplyC,
	input logic        progSupply,
	input logic        progPause,
	input logic        functionCode,
	input logic        irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// ----------------
	// shadow registers
	// ----------------
	logic [15:0] c1_r, pd_r, ie_r, db_r, dc_r;
	logic [2:0]  cl_r;
	logic        wr;
	assign wr = psel && penable && pwrite;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			{c1_r, pd_r, ie_r, db_r, dc_r, cl_r} <= '0;
		end else begin
			if (wr && paddr == 12'h000) c1_r <= pwdata[15:0];
			if (wr && paddr == 12'h004) cl_r <= pwdata[7:5];
			if (wr && paddr == 12'h008) pd_r <= pwdata[15:0];
			if (wr && paddr == 12'h00c) ie_r <= pwdata[15:0];
			if (wr && paddr == 12'h058) db_r <= pwdata[15:0];
			dc_r <= cardDetectInput ? dc_r + 16'(dc_r != 16'hffff) : '0;
		end
	end
	sequence sRd(a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	sequence sHeld;
		$stable(pd_r) [*8];
	endsequence
	sequence sHalted;
		(c1_r[6] && !pd_r[0] && (supplyA || supplyB || supplyC)
			&& $stable(cardClk)) [*8];
	endsequence
	// ----------------
	// properties
	// ----------------
	AST_IRQ_GIE: assert property (irq |-> c1_r[15])
		else $error("irq with global enable low");
	AST_IRQ_SRC: assert property (irq |-> ie_r != 16'h0)
		else $error("irq with no enable set");
	AST_WARM_RD: assert property (sRd(12'h004) |-> !prdata[2])
		else $error("warm restart bit read as one");
	AST_PRESENT: assert property (
		sRd(12'h008) ##0 prdata[9] |-> dc_r >= db_r)
		else $error("card present before debounce");
	AST_RAW_PADS: assert property (
		sHeld ##0 pd_r[0] |-> {cardResetN, cardClk, cardIoOeN} == pd_r[3:1])
		else $error("raw pads not followed");
	AST_RAW_VCC: assert property (
		sHeld ##0 pd_r[0] |-> {supplyA, supplyB, supplyC} == ({3{pd_r[4]}} & cl_r))
		else $error("raw supply mismatch");
	AST_PAD_LVL: assert property (
		sHeld ##0 !pd_r[5] |-> {functionCode, progPause, progSupply} == pd_r[8:6])
		else $error("direct pad levels mismatch");
	AST_HALT_LVL: assert property (sHalted |-> cardClk == c1_r[7])
		else $error("halted clock at wrong level");
endmodule : scrc_props
bind scrc_top scrc_props i_scrc_props (.*);

// ---- verif/scrc_top_tb.sv ----
`timescale 1ns/1ps
module scrc_top_tb;
	logic        core_clk, resetn, linkClk, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, cardDetectInput, cardIoIn, cardIoOut;
	logic        cardIoOeN, cardClk, cardResetN, supplyA, supplyB, supplyC;
	logic        progSupply, progPause, functionCode, irq, err;
	logic [15:0] q;
	int          mismatches, cmp_count;
	scrc_top #(.CLASS_GAP_CYC(20), .RST_LOW_CYC(10), .ATR_WAIT_CYC(200))
		i_scrc_top (.*);
	scrc_card_model i_scrc_card_model (.*);
	initial begin
		core_clk = 0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		linkClk = 0;
		#37;
		forever #80 linkClk = ~linkClk;
	end
	// ----------------
	// helpers
	// ----------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		@(posedge core_clk);
		penable <= 1;
		@(posedge core_clk);
		q = prdata[15:0];
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic waitBit(input int b);
		for (int i = 0; i < 300; i++) begin
			apb(0, 12'h010, 0);
			if (q[b] === 1'b1)
				return;
		end
		chk("status wait", 16'h0, 16'h1);
		print_verdict();
	endtask : waitBit
	// ----------------
	// scenarios
	// ----------------
	task automatic tRegs();
		apb(1, 12'h004, 16'h0004);
		apb(0, 12'h004, 0);
		chk("warm readback", q, 16'h0000);
		apb(0, 12'h100, 0);
		chk("unmapped error", {15'h0, err}, 16'h0001);
		chk("unmapped data", q, 16'h0000);
		chk("ready", {15'h0, pready}, 16'h0001);
	endtask : tRegs
	task automatic tRaw();
		apb(1, 12'h004, 16'h0040);
		apb(1, 12'h008, 16'h01dd);
		repeat (8) @(negedge core_clk);
		chk("pads set", {7'h0, functionCode, progPause, progSupply, supplyA,
			supplyB, supplyC, cardResetN, cardClk, cardIoOeN}, 16'h01d6);
		apb(1, 12'h008, 16'h0003);
		repeat (8) @(negedge core_clk);
		chk("pads low", {7'h0, functionCode, progPause, progSupply, supplyA,
			supplyB, supplyC, cardResetN, cardClk, cardIoOeN}, 16'h0001);
		chk("io out", {15'h0, cardIoOut}, 16'h0000);
		apb(1, 12'h008, 0);
		apb(1, 12'h004, 0);
	endtask : tRaw
	task automatic tDetect();
		apb(1, 12'h058, 16'd20);
		apb(1, 12'h00c, 16'h2000);
		apb(1, 12'h000, 16'h8000);
		cardDetectInput <= 1'b1;
		apb(0, 12'h008, 0);
		chk("present early", q & 16'h0200, 16'h0000);
		repeat (30) @(negedge core_clk);
		apb(0, 12'h008, 0);
		chk("present late", q & 16'h0200, 16'h0200);
		chk("irq on", {15'h0, irq}, 16'h0001);
		apb(1, 12'h000, 0);
		repeat (2) @(negedge core_clk);
		chk("irq gated", {15'h0, irq}, 16'h0000);
		apb(1, 12'h010, 16'h2000);
		apb(0, 12'h010, 0);
		chk("status cleared", q & 16'h2000, 16'h0000);
	endtask : tDetect
	task automatic tSend();
		logic [8:0] ln;
		int         n;
		apb(1, 12'h000, 16'h0303);
		apb(1, 12'h200, 16'h00a5);
		for (n = 0; n < 60 && cardIoOeN !== 1'b0; n++)
			@(posedge linkClk);
		if (n == 60) begin
			chk("tx start", 16'h0, 16'h1);
			print_verdict();
		end else begin
			for (int b = 0; b < 9; b++) begin
				@(posedge linkClk);
				ln[b] = cardIoOeN;
			end
			chk("tx line", {7'h0, ln}, 16'h015a);
			waitBit(0);
			chk("tx events", q & 16'h0013, 16'h0013);
		end
	endtask : tSend
	task automatic tSession();
		apb(1, 12'h01c, 16'h0001);
		apb(1, 12'h010, 16'h0200);
		apb(1, 12'h000, 16'h0200);
		apb(1, 12'h004, 16'h0008);
		waitBit(9);
		apb(0, 12'h200, 0);
		chk("stored char", q, 16'h005a);
		apb(0, 12'h004, 0);
		chk("chosen class", q, 16'h0020);
		apb(1, 12'h000, 16'h02c0);
		repeat (40) @(negedge core_clk);
		chk("halted clock", {15'h0, cardClk}, 16'h0001);
		apb(0, 12'h000, 0);
		chk("halt readback", q, 16'h02c0);
		apb(1, 12'h000, 16'h0200);
		apb(0, 12'h000, 0);
		chk("resume readback", q, 16'h0240);
		tSend();
		apb(1, 12'h004, 16'h0010);
		waitBit(15);
		apb(0, 12'h004, 0);
		chk("down cleared", q & 16'h0010, 16'h0000);
	endtask : tSession
	initial begin
		{resetn, psel, penable, pwrite, cardDetectInput} = '0;
		paddr = '0;
		pwdata = '0;
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		tRegs();
		tRaw();
		tDetect();
		tSession();
		print_verdict();
	end
endmodule : scrc_top_tb
